// >>> logic/modem_delta.sv
// change detector and level mux for the four modem status inputs
// assumes inputs already synchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module modem_delta (
  input wire logic mclk,
  input wire logic reset,
  input wire logic loopback,
  input wire logic [3:0] loop_levels,
  input wire logic [3:0] pins_n,
  input wire logic clear,
  output logic [3:0] delta,
  output logic [3:0] level
);
  logic [3:0] prev_level;
  logic [3:0] next_delta;
  wire [3:0] cur_level = loopback ? loop_levels : ~pins_n;
  wire [3:0] changed = cur_level ^ prev_level;
  // ring delta only on trailing edge of ring: asserted level falls, pin goes high
  wire [3:0] event_hit = {changed[3], changed[2] & prev_level[2], changed[1:0]};
  // a change in the read cycle survives the clear
  assign next_delta = (clear ? 4'h0 : delta) | event_hit;
  assign level = cur_level;
  always_ff @(posedge mclk) begin
    if (reset) begin
      delta <= 4'h0;
      prev_level <= cur_level;
    end else begin
      delta <= next_delta;
      prev_level <= cur_level;
    end
  end
endmodule
`default_nettype wire

// >>> logic/uart_status_pkg.sv
// constants shared by the status and auxiliary register logic of one serial channel
// assumes a byte-wide register port addressed by a 3-bit register select
package uart_status_pkg;
  // register selects on the 3-bit address
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_ISR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SPR = 3'h7;
  // reset values
  localparam logic [7:0] RST_IER = 8'h00;
  localparam logic [7:0] RST_ISR = 8'h01;
  localparam logic [7:0] RST_LCR = 8'h00;
  localparam logic [7:0] RST_MCR = 8'h00;
  localparam logic [7:0] RST_LSR = 8'h60;
  localparam logic [7:0] RST_SPR = 8'hFF;
  localparam logic [15:0] RST_DIV = 16'h0001;
  // line status bits
  localparam int LS_RX_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_TX_IDLE = 6;
  // interrupt enable bits
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  // control bits
  localparam int LC_DIV_ACCESS = 7;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  // interrupt ident codes
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_LINE = 4'h6;
  localparam logic [3:0] ID_RX = 4'h4;
  localparam logic [3:0] ID_TX = 4'h2;
  localparam logic [3:0] ID_MODEM = 4'h0;
endpackage

// >>> logic/uart_status_regs.sv
// line/modem status, scratch and divisor registers of one serial channel
// assumes one-cycle read/write strobes and event pulses from the serial shifters
// Summary of operation
// - receive-ready bit 0 set while a character sits in receive holding
// - overrun sets bit 1, new character dropped, held one kept
// - overrun raises line-status interrupt at once when enable bit 2 set
// - parity error bit 2 belongs to held character, interrupts when enabled
// - framing error bit 3 belongs to held character, interrupts when enabled
// - break bit 4 set after a full low frame, held until line status is read after line marks
// - holding-empty bit 5 set on transfer to shift, cleared on host write
// - holding-empty with transmit enable requests an interrupt
// - bit 6 high only when holding and shift registers both empty
// - modem deltas 0,1,3 set on any change of cts, dsr, cd
// - ring delta bit 2 set only on ring input low to high
// - any modem delta with enable bit 3 raises modem interrupt
// - modem bits 7..4 show inverted cd, ring, dsr, cts inputs
// - loopback takes modem levels from control rts, dtr, bit 2, bit 3
// - scratch register is plain 8-bit storage, 0xFF after reset
// - 16-bit divisor reachable only while line control bit 7 is one
// - reset values of enables, ident, control, status and output pins
// - reset clears modem deltas, levels show inverted inputs
// - reading line status clears the line-status interrupt
// - reading modem status clears the modem-status interrupt
// - modem control bit 4 enters and leaves internal loopback
`timescale 1ns/1ns
`default_nettype none
module uart_status_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic rx_done,
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_err,
  input wire logic rx_framing_err,
  input wire logic rx_break,
  input wire logic tx_load,
  input wire logic tx_shift_busy,
  output logic [7:0] tx_char,
  output logic [7:0] line_control,
  output logic [15:0] baud_divisor,
  input wire logic clear_to_send_n,
  input wire logic data_set_ready_n,
  input wire logic ring_indicator_n,
  input wire logic carrier_detect_n,
  output logic request_to_send_n,
  output logic terminal_ready_n,
  output logic general_output2_n,
  output logic loopback,
  output logic irq,
  output logic irq_oe_n
);
  logic [7:0] receive_holding;
  logic [7:0] transmit_holding;
  logic [7:0] interrupt_enable;
  logic [7:0] modem_control;
  logic [7:0] scratch_pad;
  logic [7:0] baud_divisor_low;
  logic [7:0] baud_divisor_high;
  logic rx_ready;
  logic overrun;
  logic parity_err;
  logic framing_err;
  logic break_flag;
  logic thr_empty;
  logic tx_int_armed;
  logic [3:0] modem_delta_bits;
  logic [3:0] modem_level;

  wire div_sel = line_control[uart_status_pkg::LC_DIV_ACCESS];
  wire rd_data = rd && addr == uart_status_pkg::ADDR_DATA && !div_sel;
  wire rd_isr = rd && addr == uart_status_pkg::ADDR_ISR;
  wire rd_lsr = rd && addr == uart_status_pkg::ADDR_LSR;
  wire rd_msr = rd && addr == uart_status_pkg::ADDR_MSR;
  wire wr_thr = wr && addr == uart_status_pkg::ADDR_DATA && !div_sel;
  wire wr_dll = wr && addr == uart_status_pkg::ADDR_DATA && div_sel;
  wire wr_dlm = wr && addr == uart_status_pkg::ADDR_IER && div_sel;
  wire wr_ier = wr && addr == uart_status_pkg::ADDR_IER && !div_sel;
  wire wr_lcr = wr && addr == uart_status_pkg::ADDR_LCR;
  wire wr_mcr = wr && addr == uart_status_pkg::ADDR_MCR;
  wire wr_spr = wr && addr == uart_status_pkg::ADDR_SPR;

  // character accepted into an empty holding register or one being read in the same cycle
  wire rx_accept = rx_done && (!rx_ready || rd_data);
  wire rx_lost = rx_done && !rx_accept;

  assign loopback = modem_control[uart_status_pkg::MC_LOOP];
  assign baud_divisor = {baud_divisor_high, baud_divisor_low};
  assign tx_char = transmit_holding;

  wire tx_idle = thr_empty && !tx_shift_busy;
  wire [7:0] line_status = {1'b0, tx_idle, thr_empty, break_flag, framing_err,
                            parity_err, overrun, rx_ready};
  wire [7:0] modem_status = {modem_level, modem_delta_bits};

  wire line_int = interrupt_enable[uart_status_pkg::IE_LINE] &&
                  (overrun || parity_err || framing_err || break_flag);
  wire rx_int = interrupt_enable[uart_status_pkg::IE_RX] && rx_ready;
  wire tx_int = interrupt_enable[uart_status_pkg::IE_TX] && thr_empty && tx_int_armed;
  wire modem_int = interrupt_enable[uart_status_pkg::IE_MODEM] && |modem_delta_bits;
  wire [3:0] ident = line_int ? uart_status_pkg::ID_LINE :
                     rx_int ? uart_status_pkg::ID_RX :
                     tx_int ? uart_status_pkg::ID_TX :
                     modem_int ? uart_status_pkg::ID_MODEM : uart_status_pkg::ID_NONE;
  wire [7:0] interrupt_ident = {4'h0, ident};

  // loop levels: cts<-rts, dsr<-dtr, ring<-bit2, cd<-bit3
  wire [3:0] loop_levels = {modem_control[uart_status_pkg::MC_OUT2],
                            modem_control[uart_status_pkg::MC_OUT1],
                            modem_control[uart_status_pkg::MC_DTR],
                            modem_control[uart_status_pkg::MC_RTS]};

  modem_delta u_modem_delta (
    .mclk(mclk),
    .reset(reset),
    .loopback(loopback),
    .loop_levels(loop_levels),
    .pins_n({carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n}),
    .clear(rd_msr),
    .delta(modem_delta_bits),
    .level(modem_level)
  );

  // outputs held high in loopback so the modem sees an idle interface
  assign request_to_send_n = loopback | ~modem_control[uart_status_pkg::MC_RTS];
  assign terminal_ready_n = loopback | ~modem_control[uart_status_pkg::MC_DTR];
  assign general_output2_n = loopback | ~modem_control[uart_status_pkg::MC_OUT2];
  assign irq_oe_n = ~modem_control[uart_status_pkg::MC_OUT2];
  assign irq = ident[0] == 1'b0;

  wire [7:0] data_read = div_sel ? baud_divisor_low : receive_holding;
  wire [7:0] ier_read = div_sel ? baud_divisor_high : interrupt_enable;
  wire [7:0] next_rdata =
    addr == uart_status_pkg::ADDR_DATA ? data_read :
    addr == uart_status_pkg::ADDR_IER ? ier_read :
    addr == uart_status_pkg::ADDR_ISR ? interrupt_ident :
    addr == uart_status_pkg::ADDR_LCR ? line_control :
    addr == uart_status_pkg::ADDR_MCR ? modem_control :
    addr == uart_status_pkg::ADDR_LSR ? line_status :
    addr == uart_status_pkg::ADDR_MSR ? modem_status : scratch_pad;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      interrupt_enable <= uart_status_pkg::RST_IER;
      line_control <= uart_status_pkg::RST_LCR;
      modem_control <= uart_status_pkg::RST_MCR;
      scratch_pad <= uart_status_pkg::RST_SPR;
      baud_divisor_low <= uart_status_pkg::RST_DIV[7:0];
      baud_divisor_high <= uart_status_pkg::RST_DIV[15:8];
    end else begin
      if (wr_ier) interrupt_enable <= {4'h0, wdata[3:0]};
      if (wr_lcr) line_control <= wdata;
      if (wr_mcr) modem_control <= {3'h0, wdata[4:0]};
      if (wr_spr) scratch_pad <= wdata;
      if (wr_dll) baud_divisor_low <= wdata;
      if (wr_dlm) baud_divisor_high <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      receive_holding <= 8'h00;
      transmit_holding <= 8'h00;
    end else begin
      if (rx_accept) receive_holding <= rx_char;
      if (wr_thr) transmit_holding <= wdata;
    end
  end

  // receive flags: hardware set wins over a read clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_ready <= uart_status_pkg::RST_LSR[uart_status_pkg::LS_RX_READY];
      overrun <= uart_status_pkg::RST_LSR[uart_status_pkg::LS_OVERRUN];
      parity_err <= uart_status_pkg::RST_LSR[uart_status_pkg::LS_PARITY];
      framing_err <= uart_status_pkg::RST_LSR[uart_status_pkg::LS_FRAMING];
      break_flag <= uart_status_pkg::RST_LSR[uart_status_pkg::LS_BREAK];
    end else begin
      rx_ready <= rx_accept | (rx_ready & ~rd_data);
      overrun <= rx_lost | (overrun & ~rd_lsr);
      parity_err <= (rx_accept & rx_parity_err) | (parity_err & ~rd_lsr & ~rx_accept);
      framing_err <= (rx_accept & rx_framing_err) | (framing_err & ~rd_lsr & ~rx_accept);
      // break stays while the line is low, read cannot clear it early
      break_flag <= rx_break | (break_flag & ~rd_lsr);
    end
  end

  // holding-empty: transfer sets it, host write clears it at the same edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      thr_empty <= uart_status_pkg::RST_LSR[uart_status_pkg::LS_THR_EMPTY];
      tx_int_armed <= 1'b1;
    end else begin
      if (wr_thr) thr_empty <= 1'b0;
      else if (tx_load) thr_empty <= 1'b1;
      // ident read drops the transmit request until next empty event
      if (wr_thr || tx_load) tx_int_armed <= 1'b1;
      else if (rd_isr && ident == uart_status_pkg::ID_TX) tx_int_armed <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> verification/modem_far.sv
// far-side modem levels and received character events
// assumes requests from the bench change only at falling edges
`timescale 1ns/1ns
`default_nettype none
module modem_far (
  input wire logic mclk,
  input wire logic [3:0] want_pins_n,
  input wire logic send,
  input wire logic [9:0] frame,
  output logic [3:0] pins_n = 4'hF,
  output logic rx_done = 1'b0,
  output logic [7:0] rx_char = 8'h00,
  output logic rx_parity_err = 1'b0,
  output logic rx_framing_err = 1'b0
);
  // idle data toggles so a stale byte is never taken for a fresh one
  always @(negedge mclk) begin
    pins_n <= want_pins_n;
    rx_done <= send;
    {rx_parity_err, rx_framing_err, rx_char} <= send ? frame : {2'b00, ~rx_char};
  end
endmodule
`default_nettype wire

// >>> verification/uart_status_asserts.sv
// concurrent checks on the port behaviour of the status register block
// assumes one-cycle rd and wr strobes sampled at rising mclk
`timescale 1ns/1ns
`default_nettype none
module uart_status_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rx_done,
  input wire logic [7:0] tx_char,
  input wire logic [7:0] line_control,
  input wire logic [15:0] baud_divisor,
  input wire logic request_to_send_n,
  input wire logic terminal_ready_n,
  input wire logic general_output2_n,
  input wire logic loopback,
  input wire logic irq_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire div_sel = line_control[uart_status_pkg::LC_DIV_ACCESS];
  wire outs_idle = request_to_send_n && terminal_ready_n && general_output2_n;
  wire wr_lo = wr && addr == 3'h0;
  a_reset_outs: assert property ($fell(reset) |-> outs_idle && irq_oe_n && !loopback
    && rdata == 8'h00 && line_control == 8'h00) else $error("outputs not at reset level");
  a_div_low: assert property (wr_lo && div_sel |=> baud_divisor[7:0] == $past(wdata))
    else $error("divisor low byte not written");
  a_div_high: assert property (wr && addr == 3'h1 && div_sel
    |=> baud_divisor[15:8] == $past(wdata)) else $error("divisor high byte not written");
  a_div_guard: assert property (!div_sel |=> $stable(baud_divisor))
    else $error("divisor changed while not selected");
  a_tx_hold: assert property (wr_lo && !div_sel |=> tx_char == $past(wdata))
    else $error("holding byte not loaded");
  a_loop_force: assert property (loopback |-> outs_idle)
    else $error("modem outputs active in loopback");
  a_loop_enter: assert property (wr && addr == 3'h4 |=> loopback == $past(wdata[4]))
    else $error("loopback does not follow control bit");
  a_irq_enable: assert property (!loopback |-> irq_oe_n == general_output2_n)
    else $error("interrupt enable and output2 disagree");
  c_rx: cover property (rx_done);
  c_loop: cover property (loopback && wr);
  c_div: cover property (wr && div_sel);
  c_status: cover property (rd && addr == 3'h5);
endmodule
bind uart_status_regs uart_status_asserts uart_status_asserts_i (.mclk, .reset, .addr, .rd, .wr,
  .wdata, .rdata, .rx_done, .tx_char, .line_control, .baud_divisor, .request_to_send_n,
  .terminal_ready_n, .general_output2_n, .loopback, .irq_oe_n);
`default_nettype wire

// >>> verification/uart_status_scratch_divisor_test.sv
// self-checking bench for the status, scratch and divisor registers
// assumes modem_far on the serial side; bus driven at falling edges
`timescale 1ns/1ns
`default_nettype none
module uart_status_scratch_divisor_test;
  logic mclk = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0, send = 1'b0;
  logic tx_load = 1'b0, busy = 1'b0, brk = 1'b0, irq, irq_oe_n, rx_done, perr, ferr;
  logic rts_n, dtr_n, op2_n;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, rx_char;
  logic [3:0] want = 4'hE, pins_n;
  logic [9:0] frame = 10'h000;
  int num_errors = 0, cmp_count = 0;
  always #25 mclk = ~mclk;
  modem_far modem_far_i (.mclk, .want_pins_n(want), .send, .frame, .pins_n, .rx_done,
    .rx_char, .rx_parity_err(perr), .rx_framing_err(ferr));
  uart_status_regs uart_status_regs_i (.mclk, .reset, .addr, .rd, .wr, .wdata, .rdata,
    .rx_done, .rx_char, .rx_parity_err(perr), .rx_framing_err(ferr), .rx_break(brk),
    .tx_load, .tx_shift_busy(busy), .tx_char(), .line_control(), .baud_divisor(),
    .clear_to_send_n(pins_n[0]), .data_set_ready_n(pins_n[1]), .ring_indicator_n(pins_n[2]),
    .carrier_detect_n(pins_n[3]), .request_to_send_n(rts_n), .terminal_ready_n(dtr_n),
    .general_output2_n(op2_n), .loopback(), .irq, .irq_oe_n);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(negedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(negedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(negedge mclk);
    rd <= 1'b0;
    chk(rdata & m, e);
  endtask
  task automatic rx(input logic [9:0] f);
    @(negedge mclk);
    frame <= f;
    send <= 1'b1;
    @(negedge mclk);
    send <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic pins(input logic [3:0] p);
    want <= p;
    repeat (3) @(negedge mclk);
  endtask
  task automatic t_reset;
    logic [7:0] exp [1:5];
    exp = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60};
    reset <= 1'b1;
    repeat (12) @(negedge mclk);
    reset <= 1'b0;
    chk({4'h0, irq_oe_n, op2_n, dtr_n, rts_n}, 8'h0F);
    for (int a = 1; a < 6; a++) rd_chk(3'(a), exp[a]);
    rd_chk(3'h6, {~want, 4'h0});
    rd_chk(3'h7, 8'hFF);
    $display("reset test done");
  endtask
  task automatic t_scratch;
    wr_reg(3'h7, 8'h5A);
    rd_chk(3'h7, 8'h5A);
    rd_chk(3'h5, 8'h60);
    $display("scratch test done");
  endtask
  task automatic t_divisor;
    wr_reg(3'h3, 8'h80);
    wr_reg(3'h0, 8'h0C);
    wr_reg(3'h1, 8'h34);
    rd_chk(3'h0, 8'h0C);
    rd_chk(3'h1, 8'h34);
    wr_reg(3'h3, 8'h03);
    rd_chk(3'h1, 8'h00);
    wr_reg(3'h3, 8'h00);
    $display("divisor test done");
  endtask
  task automatic t_tx;
    wr_reg(3'h0, 8'h77);
    rd_chk(3'h5, 8'h00);
    @(negedge mclk);
    tx_load <= 1'b1;
    busy <= 1'b1;
    @(negedge mclk);
    tx_load <= 1'b0;
    rd_chk(3'h5, 8'h20);
    wr_reg(3'h1, 8'h02);
    chk({7'h00, irq}, 8'h01);
    rd_chk(3'h2, 8'h02);
    chk({7'h00, irq}, 8'h00);
    busy <= 1'b0;
    rd_chk(3'h5, 8'h60);
    wr_reg(3'h1, 8'h00);
    $display("transmit test done");
  endtask
  task automatic t_rx;
    wr_reg(3'h1, 8'h04);
    rx(10'h011);
    rd_chk(3'h5, 8'h61);
    rx(10'h022);
    chk({7'h00, irq}, 8'h01);
    rd_chk(3'h2, 8'h06);
    rd_chk(3'h5, 8'h63);
    chk({7'h00, irq}, 8'h00);
    rd_chk(3'h5, 8'h61);
    rd_chk(3'h0, 8'h11);
    rd_chk(3'h5, 8'h60);
    rx(10'h333);
    chk({7'h00, irq}, 8'h01);
    rd_chk(3'h5, 8'h6D);
    rd_chk(3'h0, 8'h33);
    brk <= 1'b1;
    rd_chk(3'h5, 8'h70);
    chk({7'h00, irq}, 8'h01);
    rd_chk(3'h5, 8'h70);
    brk <= 1'b0;
    rd_chk(3'h5, 8'h60, 8'hEF);
    rd_chk(3'h5, 8'h60);
    wr_reg(3'h1, 8'h00);
    $display("receive test done");
  endtask
  task automatic t_modem;
    wr_reg(3'h1, 8'h08);
    pins(4'hF);
    chk({7'h00, irq}, 8'h01);
    rd_chk(3'h2, 8'h00);
    rd_chk(3'h6, 8'h01);
    chk({7'h00, irq}, 8'h00);
    pins(4'hB);
    rd_chk(3'h6, 8'h40);
    pins(4'hF);
    rd_chk(3'h6, 8'h04);
    pins(4'h5);
    rd_chk(3'h6, 8'hAA);
    wr_reg(3'h4, 8'h13);
    rd_chk(3'h6, 8'h30, 8'hF0);
    chk({4'h0, irq_oe_n, op2_n, dtr_n, rts_n}, 8'h0F);
    wr_reg(3'h4, 8'h1C);
    rd_chk(3'h6, 8'hC0, 8'hF0);
    wr_reg(3'h4, 8'h0C);
    rd_chk(3'h6, 8'hA0, 8'hF0);
    chk({4'h0, irq_oe_n, op2_n, dtr_n, rts_n}, 8'h03);
    wr_reg(3'h1, 8'h00);
    $display("modem test done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    t_reset();
    t_scratch();
    t_reset();
    t_divisor();
    t_tx();
    t_rx();
    t_modem();
    give_verdict();
  end
  // watchdog so a stuck run still reaches the verdict
  initial begin
    #1000000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
